/* flash_command_decoder.sv */
`timescale 1ns/1ps
// Summary of operation
// - Reset op writes F0 anywhere; ends autoselect, back to array reads.
// - Every command step is a write strobe except autoselect/array reads.
// - Program: three unlock/command writes then location and value.
// - Autoselect: unlock, unlock, 90, then read of the code offset.
// - Bypass entry is unlock, unlock, 20; required before bypass program.
// - Bypass program is A0 anywhere then location and value.
// - Bypass exit writes 90 then 00 anywhere; array reads follow.
// - Erase is six writes ending 555/10 chip or sector/30.
module flash_command_decoder #(
	parameter int SUSPEND_WAIT_CYC = flash_cmd_pkg::SUSPEND_CYC, // suspend settle cycles
	parameter int WINDOW_WAIT_CYC = flash_cmd_pkg::WINDOW_CYC // sector add window cycles
) (
	input wire logic clock_in, // 250 MHz clock
	input wire logic rst_n_in, // synchronous reset, active low
	input wire logic cmd_valid_in, // command request
	input wire flash_cmd_pkg::cmd_t cmd_in, // operation, mode, location, value
	output logic cmd_ready_out, // controller idle, request taken
	output logic done_out, // one-cycle completion pulse
	output logic error_out, // with done: command refused in this mode
	output logic [15:0] read_data_out, // data of the last read
	output logic [5:0] mode_out, // autosel, bypass, erasing, sector, suspended, window
	output logic [19:0] flash_addr_out, // flash address pins
	input wire logic [15:0] flash_dq_in, // flash data pins, input side
	output logic [15:0] flash_dq_out, // flash data pins, output side
	output logic flash_dq_oe_out, // high while the data pins are driven
	output logic flash_ce_n_out, // chip select, active low
	output logic flash_oe_n_out, // output enable, active low
	output logic flash_we_n_out, // write strobe, active low
	output logic flash_byte_n_out, // low selects byte mode
	output logic flash_reset_n_out, // flash hardware reset, active low
	input wire logic flash_ready_in // ready/busy pin, high when ready
);
	import flash_cmd_pkg::*;

	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_ISSUE = 2'b01,
		M_WAIT = 2'b10,
		M_SETTLE = 2'b11
	} main_state_t;

	main_state_t state_ff;
	cmd_t cmd_ff;
	logic [2:0] step_ff;
	logic [15:0] settle_ff;
	logic [15:0] window_ff;
	logic done_ff, err_ff, autosel_ff, bypass_ff, erasing_ff, sector_ff, suspended_ff;
	logic ready_meta_ff, ready_sync_ff, ready_prev_ff;
	logic bus_done, last_step, fin, accept, window_open;
	logic [15:0] bus_rdata;
	cycle_t cur_cycle;

	// ----------------------------------------------------------------
	// Sequence decoding
	// ----------------------------------------------------------------
	function automatic logic [2:0] seq_len(input op_t op);
		case (op)
			OP_ID_READ, OP_PROTECT_VERIFY, OP_PROGRAM: seq_len = 3'd4;
			OP_BYPASS_ENTER: seq_len = 3'd3;
			OP_BYPASS_PROGRAM, OP_BYPASS_RESET: seq_len = 3'd2;
			OP_CHIP_ERASE, OP_SECTOR_ERASE: seq_len = 3'd6;
			default: seq_len = 3'd1;
		endcase
	endfunction

	function automatic cycle_t cycle_at(input cmd_t c, input logic [2:0] idx);
		cycle_t r;
		logic [19:0] a1;
		logic [19:0] a2;
		logic erase;
		r = '{rd: 1'b0, addr: 20'h00000, data: 16'h0000};
		a1 = c.bm ? ADDR_U1_BYTE : ADDR_U1_WORD;
		a2 = c.bm ? ADDR_U2_BYTE : ADDR_U2_WORD;
		erase = (c.op == OP_CHIP_ERASE) || (c.op == OP_SECTOR_ERASE);
		if (seq_len(c.op) >= 3'd3 && (idx == 3'd0 || (erase && idx == 3'd3))) begin
			r.addr = a1;
			r.data = CMD_UNLOCK1;
		end else if (seq_len(c.op) >= 3'd3 && (idx == 3'd1 || (erase && idx == 3'd4))) begin
			r.addr = a2;
			r.data = CMD_UNLOCK2;
		end else if (seq_len(c.op) >= 3'd3 && idx == 3'd2) begin
			r.addr = a1;
			case (c.op)
				OP_PROGRAM: r.data = CMD_PROGRAM;
				OP_BYPASS_ENTER: r.data = CMD_BYPASS;
				OP_CHIP_ERASE, OP_SECTOR_ERASE: r.data = CMD_ERASE_SETUP;
				default: r.data = CMD_AUTOSEL;
			endcase
		end else begin
			case (c.op)
				OP_READ, OP_ID_READ: begin
					r.rd = 1'b1;
					r.addr = c.addr;
				end
				OP_PROTECT_VERIFY: begin
					r.rd = 1'b1;
					r.addr = c.bm ? {c.addr[19:13], PROT_OFS_BYTE} : {1'b0, c.addr[18:12], PROT_OFS_WORD};
				end
				OP_RESET: r.data = CMD_RESET;
				OP_PROGRAM: begin
					r.addr = c.addr;
					r.data = c.data;
				end
				OP_BYPASS_PROGRAM: begin
					r.addr = (idx == 3'd0) ? 20'h00000 : c.addr;
					r.data = (idx == 3'd0) ? CMD_PROGRAM : c.data;
				end
				OP_BYPASS_RESET: r.data = (idx == 3'd0) ? CMD_BYP_RESET1 : CMD_BYP_RESET2;
				OP_CHIP_ERASE: begin
					r.addr = a1;
					r.data = CMD_CHIP_ERASE;
				end
				OP_SECTOR_ERASE, OP_SECTOR_ADD: begin
					r.addr = c.addr;
					r.data = CMD_SECTOR_ERASE;
				end
				OP_SUSPEND: r.data = CMD_SUSPEND;
				default: r.data = CMD_RESUME;
			endcase
		end
		return r;
	endfunction

	function automatic logic legal(input op_t op, input logic [5:0] m);
		// Mode vector order: autosel, bypass, erasing, sector, suspended, window.
		if (m[4]) begin
			legal = (op == OP_READ) || (op == OP_BYPASS_PROGRAM) || (op == OP_BYPASS_RESET);
		end else if (m[3] && !m[1]) begin
			legal = (op == OP_READ) || (op == OP_RESET) || (op == OP_SUSPEND && m[2])
				|| (op == OP_SECTOR_ADD && m[0]);
		end else if (m[5]) begin
			legal = (op == OP_READ) || (op == OP_RESET) || (op == OP_ID_READ)
				|| (op == OP_PROTECT_VERIFY);
		end else if (m[1]) begin
			legal = (op == OP_READ) || (op == OP_PROGRAM) || (op == OP_ID_READ)
				|| (op == OP_PROTECT_VERIFY) || (op == OP_RESET) || (op == OP_RESUME);
		end else begin
			legal = !(op inside {OP_BYPASS_PROGRAM, OP_BYPASS_RESET, OP_SUSPEND,
				OP_RESUME, OP_SECTOR_ADD});
		end
	endfunction

	assign window_open = (window_ff != 16'h0000);
	assign mode_out = {autosel_ff, bypass_ff, erasing_ff, sector_ff, suspended_ff, window_open};
	assign cmd_ready_out = (state_ff == M_IDLE);
	assign accept = cmd_valid_in && cmd_ready_out && legal(cmd_in.op, mode_out);
	assign cur_cycle = cycle_at(cmd_ff, step_ff);
	assign last_step = (step_ff == seq_len(cmd_ff.op) - 3'd1);
	assign fin = (state_ff == M_WAIT && bus_done && last_step && cmd_ff.op != OP_SUSPEND)
		|| (state_ff == M_SETTLE && settle_ff == 16'h0000);
	assign done_out = done_ff;
	assign error_out = err_ff;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		done_ff <= 1'b0;
		err_ff <= 1'b0;
		if (!rst_n_in) begin
			state_ff <= M_IDLE;
			cmd_ff <= '0;
			step_ff <= 3'd0;
			settle_ff <= 16'h0000;
			read_data_out <= 16'h0000;
		end else begin
			case (state_ff)
				M_IDLE: begin
					if (cmd_valid_in && !accept) begin
						done_ff <= 1'b1;
						err_ff <= 1'b1;
					end else if (accept) begin
						cmd_ff <= cmd_in;
						// Already in autoselect: only the code read is needed.
						step_ff <= (autosel_ff && (cmd_in.op == OP_ID_READ
							|| cmd_in.op == OP_PROTECT_VERIFY)) ? 3'd3 : 3'd0;
						state_ff <= M_ISSUE;
					end
				end
				M_ISSUE: state_ff <= M_WAIT;
				M_WAIT: begin
					if (bus_done) begin
						if (!last_step) begin
							step_ff <= step_ff + 3'd1;
							state_ff <= M_ISSUE;
						end else if (cmd_ff.op == OP_SUSPEND) begin
							settle_ff <= 16'(SUSPEND_WAIT_CYC - 1);
							state_ff <= M_SETTLE;
						end else begin
							if (cur_cycle.rd) begin
								read_data_out <= bus_rdata;
							end
							done_ff <= 1'b1;
							state_ff <= M_IDLE;
						end
					end
				end
				M_SETTLE: begin
					if (settle_ff == 16'h0000) begin
						done_ff <= 1'b1;
						state_ff <= M_IDLE;
					end else begin
						settle_ff <= settle_ff - 16'h0001;
					end
				end
				default: state_ff <= M_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Device mode tracking
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		ready_meta_ff <= flash_ready_in;
		ready_sync_ff <= ready_meta_ff;
		ready_prev_ff <= ready_sync_ff;
	end

	// A completed command is applied after the end-of-erase check, so a
	// new erase finishing in the same cycle as a ready edge is kept.
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			autosel_ff <= 1'b0;
			bypass_ff <= 1'b0;
			erasing_ff <= 1'b0;
			sector_ff <= 1'b0;
			suspended_ff <= 1'b0;
			window_ff <= 16'h0000;
			flash_reset_n_out <= 1'b0;
			flash_byte_n_out <= 1'b1;
		end else begin
			flash_reset_n_out <= 1'b1;
			flash_byte_n_out <= !cmd_ff.bm;
			if (window_open) begin
				window_ff <= window_ff - 16'h0001;
			end
			if (erasing_ff && !suspended_ff && !window_open && ready_sync_ff && !ready_prev_ff) begin
				erasing_ff <= 1'b0;
				sector_ff <= 1'b0;
			end
			if (fin) begin
				case (cmd_ff.op)
					OP_RESET: begin
						autosel_ff <= 1'b0;
						if (!suspended_ff) begin
							erasing_ff <= 1'b0;
							sector_ff <= 1'b0;
						end
					end
					OP_ID_READ, OP_PROTECT_VERIFY: autosel_ff <= 1'b1;
					OP_BYPASS_ENTER: bypass_ff <= 1'b1;
					OP_BYPASS_RESET: bypass_ff <= 1'b0;
					OP_CHIP_ERASE: begin
						erasing_ff <= 1'b1;
						sector_ff <= 1'b0;
					end
					OP_SECTOR_ERASE, OP_SECTOR_ADD: begin
						erasing_ff <= 1'b1;
						sector_ff <= 1'b1;
						window_ff <= 16'(WINDOW_WAIT_CYC - 1);
					end
					OP_SUSPEND: begin
						suspended_ff <= 1'b1;
						window_ff <= 16'h0000;
					end
					OP_RESUME: suspended_ff <= 1'b0;
					default: ;
				endcase
			end
		end
	end

	flash_bus_cycle u_flash_bus_cycle (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.start_in(state_ff == M_ISSUE),
		.cyc_in(cur_cycle),
		.done_out(bus_done),
		.rdata_out(bus_rdata),
		.flash_addr_out(flash_addr_out),
		.flash_dq_in(flash_dq_in),
		.flash_dq_out(flash_dq_out),
		.flash_dq_oe_out(flash_dq_oe_out),
		.flash_ce_n_out(flash_ce_n_out),
		.flash_oe_n_out(flash_oe_n_out),
		.flash_we_n_out(flash_we_n_out)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence suspend_written;
		state_ff == M_WAIT && bus_done && cmd_ff.op == OP_SUSPEND;
	endsequence

	chk_refuse_quiet: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(cmd_valid_in && cmd_ready_out && !accept) |=> done_out && error_out && flash_ce_n_out)
		else $error("refused command not reported or started a cycle");
	chk_read_direct: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(accept && cmd_in.op == OP_READ) |-> flash_we_n_out [*3] ##1 !flash_oe_n_out)
		else $error("array read did not start directly");
	chk_suspend_settle: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		suspend_written |=> (!done_out && state_ff == M_SETTLE) [*8])
		else $error("suspend completed before settle time");
	chk_window_reload: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(fin && cmd_ff.op == OP_SECTOR_ADD) |=> window_ff == 16'(WINDOW_WAIT_CYC - 1) && sector_ff)
		else $error("sector window not restarted");
	chk_reset_exits: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(fin && cmd_ff.op == OP_RESET) |=> !autosel_ff && done_out)
		else $error("reset did not leave autoselect");
	chk_bypass_exit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(fin && cmd_ff.op == OP_BYPASS_RESET) |=> !bypass_ff)
		else $error("bypass mode not left");
	chk_reset_pin: assert property (@(posedge clock_in)
		!rst_n_in |=> !flash_reset_n_out && flash_ce_n_out && !done_out)
		else $error("flash reset pin not asserted during reset");
endmodule

/* flash_cmd_pkg.sv */
package flash_cmd_pkg;

	// ----------------------------------------------------------------
	// Host operations
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_READ = 4'h0,
		OP_RESET = 4'h1,
		OP_ID_READ = 4'h2,
		OP_PROTECT_VERIFY = 4'h3,
		OP_PROGRAM = 4'h4,
		OP_BYPASS_ENTER = 4'h5,
		OP_BYPASS_PROGRAM = 4'h6,
		OP_BYPASS_RESET = 4'h7,
		OP_CHIP_ERASE = 4'h8,
		OP_SECTOR_ERASE = 4'h9,
		OP_SECTOR_ADD = 4'hA,
		OP_SUSPEND = 4'hB,
		OP_RESUME = 4'hC
	} op_t;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic rd;
		logic [19:0] addr;
		logic [15:0] data;
	} cycle_t;

	typedef struct packed {
		op_t op;
		logic bm;
		logic [19:0] addr;
		logic [15:0] data;
	} cmd_t;

	// ----------------------------------------------------------------
	// Unlock addresses and command values
	// ----------------------------------------------------------------
	localparam logic [19:0] ADDR_U1_WORD = 20'h00555;
	localparam logic [19:0] ADDR_U2_WORD = 20'h002AA;
	localparam logic [19:0] ADDR_U1_BYTE = 20'h00AAA;
	localparam logic [19:0] ADDR_U2_BYTE = 20'h00555;
	localparam logic [11:0] PROT_OFS_WORD = 12'h002;
	localparam logic [12:0] PROT_OFS_BYTE = 13'h0004;
	localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
	localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
	localparam logic [15:0] CMD_RESET = 16'h00F0;
	localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
	localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
	localparam logic [15:0] CMD_BYPASS = 16'h0020;
	localparam logic [15:0] CMD_BYP_RESET1 = 16'h0090;
	localparam logic [15:0] CMD_BYP_RESET2 = 16'h0000;
	localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
	localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
	localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
	localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
	localparam logic [15:0] CMD_RESUME = 16'h0030;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int T_WP_NS = 30;
	localparam int T_ACC_NS = 70;
	localparam int T_REC_NS = 20;
	localparam int T_SUSPEND_NS = 20000;
	localparam int T_WINDOW_NS = 50000;
	localparam int SYNC_STAGES = 2;
	localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
	localparam int REC_CYC = (T_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SUSPEND_CYC = (T_SUSPEND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WINDOW_CYC = T_WINDOW_NS / CLK_PERIOD_NS;

endpackage

/* flash_bus_cycle.sv */
`timescale 1ns/1ps
module flash_bus_cycle (
	input wire logic clock_in, // 250 MHz clock
	input wire logic rst_n_in, // synchronous reset, active low
	input wire logic start_in, // one-cycle start of a bus cycle
	input wire flash_cmd_pkg::cycle_t cyc_in, // cycle kind, address, data
	output logic done_out, // one-cycle end of the bus cycle
	output logic [15:0] rdata_out, // data captured by a read cycle
	output logic [19:0] flash_addr_out, // flash address pins
	input wire logic [15:0] flash_dq_in, // flash data pins, input side
	output logic [15:0] flash_dq_out, // flash data pins, output side
	output logic flash_dq_oe_out, // high while the data pins are driven
	output logic flash_ce_n_out, // chip select, active low
	output logic flash_oe_n_out, // output enable, active low
	output logic flash_we_n_out // write strobe, active low
);
	import flash_cmd_pkg::*;

	typedef enum logic [2:0] {
		B_IDLE = 3'b000,
		B_SETUP = 3'b001,
		B_PULSE = 3'b010,
		B_HOLD = 3'b011,
		B_READ = 3'b100,
		B_RECOVER = 3'b101
	} bus_state_t;

	bus_state_t state_ff;
	logic [7:0] cnt_ff;
	logic [15:0] dq_meta_ff;
	logic [15:0] dq_sync_ff;
	logic done_ff;

	// ----------------------------------------------------------------
	// Data pin synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clock_in) begin
		dq_meta_ff <= flash_dq_in;
		dq_sync_ff <= dq_meta_ff;
	end

	// ----------------------------------------------------------------
	// Cycle sequencer
	// ----------------------------------------------------------------
	// Address and data are set a full cycle before the strobe falls and
	// data is held a cycle after it rises, so both latch edges see them.
	always_ff @(posedge clock_in) begin
		done_ff <= 1'b0;
		if (!rst_n_in) begin
			state_ff <= B_IDLE;
			cnt_ff <= 8'h00;
			rdata_out <= 16'h0000;
			flash_addr_out <= 20'h00000;
			flash_dq_out <= 16'h0000;
			flash_dq_oe_out <= 1'b0;
			flash_ce_n_out <= 1'b1;
			flash_oe_n_out <= 1'b1;
			flash_we_n_out <= 1'b1;
		end else begin
			case (state_ff)
				B_IDLE: begin
					if (start_in) begin
						flash_addr_out <= cyc_in.addr;
						flash_ce_n_out <= 1'b0;
						if (cyc_in.rd) begin
							flash_oe_n_out <= 1'b0;
							cnt_ff <= 8'(ACC_CYC - 1);
							state_ff <= B_READ;
						end else begin
							flash_dq_out <= cyc_in.data;
							flash_dq_oe_out <= 1'b1;
							state_ff <= B_SETUP;
						end
					end
				end
				B_SETUP: begin
					flash_we_n_out <= 1'b0;
					cnt_ff <= 8'(WP_CYC - 1);
					state_ff <= B_PULSE;
				end
				B_PULSE: begin
					if (cnt_ff == 8'h00) begin
						flash_we_n_out <= 1'b1;
						state_ff <= B_HOLD;
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
				B_HOLD: begin
					flash_dq_oe_out <= 1'b0;
					flash_ce_n_out <= 1'b1;
					cnt_ff <= 8'(REC_CYC - 1);
					state_ff <= B_RECOVER;
				end
				B_READ: begin
					if (cnt_ff == 8'h00) begin
						rdata_out <= dq_sync_ff;
						flash_oe_n_out <= 1'b1;
						flash_ce_n_out <= 1'b1;
						cnt_ff <= 8'(REC_CYC - 1);
						state_ff <= B_RECOVER;
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
				B_RECOVER: begin
					if (cnt_ff == 8'h00) begin
						done_ff <= 1'b1;
						state_ff <= B_IDLE;
					end else begin
						cnt_ff <= cnt_ff - 8'h01;
					end
				end
				default: begin
					state_ff <= B_IDLE;
				end
			endcase
		end
	end

	assign done_out = done_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_we_under_ce: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		!flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out && flash_dq_oe_out)
		else $error("write strobe without chip select or driven data");
	chk_pulse_width: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$fell(flash_we_n_out) |-> (!flash_we_n_out) [*8] ##1 flash_we_n_out)
		else $error("write pulse width wrong");
	chk_addr_data_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		$rose(flash_we_n_out) |-> $stable(flash_addr_out) && $stable(flash_dq_out)
			&& flash_dq_oe_out && !flash_ce_n_out)
		else $error("address or data moved at write strobe rise");
	chk_no_contention: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		flash_dq_oe_out |-> flash_oe_n_out)
		else $error("data pins driven while flash outputs enabled");
endmodule

/* flash_dev_model.sv */
`timescale 1ns/1ps
module flash_dev_model #(
	parameter logic [15:0] MAKER_CODE = 16'h00C5, // Arbitrary value.
	parameter logic [15:0] DEVICE_CODE = 16'h3C3C, // Arbitrary value.
	parameter logic [6:0] LOCKED_SECTOR = 7'h05 // protected sector
) (
	input wire logic clock_in, // model clock
	input wire logic [19:0] addr_in, // address pins
	input wire logic [15:0] dq_in, // data from the host
	input wire logic dq_oe_in, // host drives data
	input wire logic ce_n_in, // chip select
	input wire logic oe_n_in, // output enable
	input wire logic we_n_in, // write strobe
	input wire logic byte_n_in, // low for byte mode
	input wire logic reset_n_in, // hardware reset
	output logic [15:0] dq_out, // data to the host
	output logic ready_out // ready pin
);
	// ----------------------------------------------------------------
	// Command decoding
	// ----------------------------------------------------------------
	logic [15:0] mem [logic [19:0]];
	logic [15:0] last_rd = 16'h0000;
	logic [127:0] gone = '0;
	logic [35:0] lat;
	int step = 0, busy = 0, n_wr = 0, viol = 0;
	logic asel = 0, byp = 0, pend = 0, byx = 0, susp = 0, era = 0;
	assign ready_out = (busy == 0);
	// A released bus shows the inverse of the last value, so stale data never looks valid.
	always @* begin
		if (ce_n_in || oe_n_in) dq_out = ~last_rd;
		else if (asel && addr_in[7:0] == 8'h00) dq_out = MAKER_CODE;
		else if (asel && addr_in[7:0] == 8'h01) dq_out = DEVICE_CODE;
		else if (asel) dq_out = {15'h0000, addr_in[18:12] == LOCKED_SECTOR};
		else if (mem.exists(addr_in) && !gone[addr_in[18:12]]) dq_out = mem[addr_in];
		else dq_out = 16'hFFFF;
	end
	always @(posedge clock_in) begin
		if (!ce_n_in && !oe_n_in) last_rd <= dq_out;
		if (dq_oe_in && !oe_n_in) viol++;
		if (busy > 0) busy--;
		if (busy == 0 && !susp) era = 0;
		if (!reset_n_in) {step, busy, asel, byp, pend, byx, susp, era} = '0;
	end
	always @(negedge we_n_in) begin
		lat = {addr_in, dq_in};
		if (ce_n_in || !dq_oe_in) viol++;
	end
	always @(posedge we_n_in) if (reset_n_in && !ce_n_in) begin
		n_wr++;
		if ({addr_in, dq_in} !== lat) viol++;
		wr(addr_in, dq_in);
	end
	task automatic wr(input logic [19:0] a, input logic [15:0] d);
		logic [7:0] c;
		logic [19:0] u1, u2;
		c = d[7:0];
		u1 = byte_n_in ? 20'h00555 : 20'h00AAA;
		u2 = byte_n_in ? 20'h002AA : 20'h00555;
		if (!pend && d[15:8] != 8'h00) viol++;
		// In byte mode the extra low address pin shifts the upper bits up by one.
		if (!pend && step != 5 && !era && (byte_n_in ? a[18:11] : a[19:12]) != 8'h00)
			viol++;
		if (pend) begin mem[a] = d; busy = 20; pend = 0; end
		else if (byx) begin byp = (c != 8'h00 && c != 8'hF0); byx = 0; end
		else if (byp) begin pend = (c == 8'hA0); byx = (c == 8'h90); end
		else if (c == 8'hB0 && era && !susp) begin susp = 1; busy = 0; end
		else if (c == 8'h30 && susp) begin susp = 0; busy = 200; end
		else if (c == 8'h30 && era && step == 0) begin gone[a[18:12]] = 1; busy = 200; end
		else if (c == 8'hF0) begin asel = 0; step = 0; end
		else if (step == 0 || step == 3) step = (a == u1 && c == 8'hAA) ? step + 1 : 0;
		else if (step == 1 || step == 4) step = (a == u2 && c == 8'h55) ? step + 1 : 0;
		else if (step == 2) begin
			step = (c == 8'h80) ? 3 : 0;
			asel = (c == 8'h90);
			pend = (c == 8'hA0);
			byp = (c == 8'h20);
		end else begin
			step = 0;
			era = (c == 8'h30);
			busy = 200;
			if (c == 8'h10) mem.delete();
			else gone[a[18:12]] = 1;
		end
	endtask
endmodule

/* flash_command_decoder_test.sv */
`timescale 1ns/1ps
module flash_command_decoder_test;
	import flash_cmd_pkg::*;
	localparam logic [15:0] MAKER = 16'h00C5;
	localparam logic [15:0] DEVICE = 16'h3C3C;
	logic clock_in = 0, rst_n_in = 0, cmd_valid_in = 0;
	cmd_t cmd_in = '0;
	logic cmd_ready_out, done_out, error_out, dq_oe, ce_n, oe_n, we_n, byte_n, frst_n, rdy;
	logic [15:0] read_data_out, dq_i, dq_o;
	logic [19:0] addr;
	logic [5:0] mode_out;
	int bad_count = 0, n_checks = 0;
	logic bm_mode = 0;
	flash_command_decoder #(.SUSPEND_WAIT_CYC(16), .WINDOW_WAIT_CYC(50)) u_flash_command_decoder (
		.clock_in(clock_in), .rst_n_in(rst_n_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
		.cmd_ready_out(cmd_ready_out), .done_out(done_out), .error_out(error_out),
		.read_data_out(read_data_out), .mode_out(mode_out), .flash_addr_out(addr),
		.flash_dq_in(dq_i), .flash_dq_out(dq_o), .flash_dq_oe_out(dq_oe), .flash_ce_n_out(ce_n),
		.flash_oe_n_out(oe_n), .flash_we_n_out(we_n), .flash_byte_n_out(byte_n),
		.flash_reset_n_out(frst_n), .flash_ready_in(rdy));
	flash_dev_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) u_flash_dev_model (
		.clock_in(clock_in), .addr_in(addr), .dq_in(dq_o), .dq_oe_in(dq_oe), .ce_n_in(ce_n),
		.oe_n_in(oe_n), .we_n_in(we_n), .byte_n_in(byte_n), .reset_n_in(frst_n),
		.dq_out(dq_i), .ready_out(rdy));
	initial forever #2 clock_in = ~clock_in;
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Program and chip erase operations wait for ready and for erase to end, so the next step is not refused.
	task run(input op_t op, input logic [19:0] a, input logic [15:0] d, input logic err, input int nw);
		int i, n0;
		n0 = u_flash_dev_model.n_wr;
		@(negedge clock_in);
		cmd_valid_in = 1;
		cmd_in = {op, bm_mode, a, d};
		for (i = 0; i < 3000 && cmd_ready_out !== 1'b1; i++) @(negedge clock_in);
		@(negedge clock_in);
		cmd_valid_in = 0;
		for (i = 0; i < 3000 && done_out !== 1'b1; i++) @(negedge clock_in);
		chk({15'h0000, done_out}, 16'h0001);
		chk({15'h0000, error_out}, {15'h0000, err});
		if (op inside {OP_PROGRAM, OP_BYPASS_PROGRAM, OP_CHIP_ERASE}) begin
			for (i = 0; i < 3000 && !(rdy === 1'b1 && mode_out[3] === 1'b0); i++) @(negedge clock_in);
			chk({15'h0000, rdy}, 16'h0001);
		end
		chk(16'(u_flash_dev_model.n_wr - n0), 16'(nw));
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_program;
		run(OP_PROGRAM, 20'h01234, 16'hA5C3, 0, 4);
		run(OP_READ, 20'h01234, 16'h0000, 0, 0);
		chk(read_data_out, 16'hA5C3);
		// Byte mode: the model only takes unlock writes at the byte addresses.
		bm_mode = 1;
		run(OP_PROGRAM, 20'h04468, 16'h005A, 0, 4);
		run(OP_READ, 20'h04468, 16'h0000, 0, 0);
		chk(read_data_out, 16'h005A);
		bm_mode = 0;
		run(OP_SUSPEND, 20'h00000, 16'h0000, 1, 0);
		run(OP_RESUME, 20'h00000, 16'h0000, 1, 0);
	endtask
	task t_autosel;
		run(OP_ID_READ, 20'h00000, 16'h0000, 0, 3);
		chk(read_data_out, MAKER);
		run(OP_ID_READ, 20'h00001, 16'h0000, 0, 0);
		chk(read_data_out, DEVICE);
		run(OP_PROTECT_VERIFY, 20'h05000, 16'h0000, 0, 0);
		chk(read_data_out, 16'h0001);
		run(OP_PROTECT_VERIFY, 20'h06000, 16'h0000, 0, 0);
		chk(read_data_out, 16'h0000);
		run(OP_PROGRAM, 20'h01236, 16'h0000, 1, 0);
		run(OP_RESET, 20'h00000, 16'h0000, 0, 1);
		run(OP_READ, 20'h01234, 16'h0000, 0, 0);
		chk(read_data_out, 16'hA5C3);
	endtask
	task t_bypass;
		run(OP_BYPASS_ENTER, 20'h00000, 16'h0000, 0, 3);
		run(OP_BYPASS_PROGRAM, 20'h02222, 16'h1E0F, 0, 2);
		run(OP_PROGRAM, 20'h02224, 16'h0000, 1, 0);
		run(OP_BYPASS_RESET, 20'h00000, 16'h0000, 0, 2);
		run(OP_READ, 20'h02222, 16'h0000, 0, 0);
		chk(read_data_out, 16'h1E0F);
	endtask
	task t_erase;
		int i;
		realtime t0;
		run(OP_SECTOR_ERASE, 20'h01000, 16'h0000, 0, 6);
		run(OP_SECTOR_ADD, 20'h03000, 16'h0000, 0, 1);
		t0 = $realtime;
		run(OP_SUSPEND, 20'h00000, 16'h0000, 0, 1);
		// One write step takes 17 cycles alone; the settle time must come on top of it.
		t0 = $realtime - t0;
		chk({15'h0000, t0 >= (WP_CYC + REC_CYC + 20) * CLK_PERIOD_NS}, 16'h0001);
		chk({15'h0000, mode_out[1]}, 16'h0001);
		run(OP_READ, 20'h02222, 16'h0000, 0, 0);
		chk(read_data_out, 16'h1E0F);
		run(OP_RESUME, 20'h00000, 16'h0000, 0, 1);
		for (i = 0; i < 3000 && mode_out[3] !== 1'b0; i++) @(negedge clock_in);
		chk({15'h0000, mode_out[3]}, 16'h0000);
		run(OP_READ, 20'h01234, 16'h0000, 0, 0);
		chk(read_data_out, 16'hFFFF);
		run(OP_CHIP_ERASE, 20'h00000, 16'h0000, 0, 6);
		run(OP_READ, 20'h02222, 16'h0000, 0, 0);
		chk(read_data_out, 16'hFFFF);
	endtask
	task give_verdict;
		if (bad_count == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clock_in);
		rst_n_in = 1;
		t_program;
		t_autosel;
		t_bypass;
		t_erase;
		chk(16'(u_flash_dev_model.viol), 16'h0000);
		give_verdict;
	end
	initial begin
		repeat (40000) @(posedge clock_in);
		bad_count++;
		give_verdict;
	end
endmodule
